// >>> fau_core.v
// Functional notes
// (RL1) Average adds both sources, drops exponent by one before rounding.
// (RL2) Average rounds nearest or truncate, at 32-bit or 40-bit boundary.
// (RL3) Rounded overflow gives infinity or largest finite; denormal gives signed zero.
// (RL4) Average flags: zero, underflow, negative, overflow, invalid; carry, sign cleared.
// (RL5) Denormal inputs become zero; any NaN input gives all-ones result.
// (RL6) Compare sets zero on equal, negative on less, invalid on NaN.
// (RL7) Compare history keeps last eight outcomes, shifting right each compare.
// (RL8) Newest history bit is greater-than: neither zero nor negative flag.
// (RL9) Negate inverts sign; zero, negative, invalid flags; others cleared.
// (RL10) Magnitude clears sign; zero, sign-of-input, invalid flags; rest cleared.
// (RL11) Pass copies source; zero, negative, invalid flags; others cleared.
// (RL12) Round to 32-bit boundary; overflow saturates and sets overflow flag.
// (RL13) Scale adds integer to exponent; overflow saturates, denormal gives zero.
// (RL14) Scale flags: zero, underflow, negative, overflow, invalid; carry, sign cleared.
// (RL15) Fraction extract gives hidden bit plus fraction, 1.31 left-justified.
// (RL16) Fraction extract: NaN or infinity all ones; zero, sign, invalid flags.
// (RL17) All seven flags update together with the result they describe.
`include "fau_defs.vh"

module fau_core (
   input wire ref_clk_i,
   input wire arst_n_i,
   input wire op_valid_i,
   input wire [`FAU_OP_W-1:0] op_code_i,
   input wire [`FAU_W-1:0] float_src_x_i,
   input wire [`FAU_W-1:0] float_src_y_i,
   input wire [31:0] fixed_scale_src_i,
   input wire rnd_trunc_i,
   input wire rnd_b32_i,
   output reg [`FAU_W-1:0] result_o,
   output reg result_we_o,
   output reg zero_flag_o,
   output reg underflow_flag_o,
   output reg negative_flag_o,
   output reg overflow_flag_o,
   output reg carry_flag_o,
   output reg sign_flag_o,
   output reg invalid_flag_o,
   output reg [`FAU_CMP_W-1:0] cmp_history_o
);

////////////////////////////////////////////////////////////////////////////////
// Shared rounding and range check; returns {overflow, underflow, zero, result}

function [`FAU_W+2:0] fau_finish;
   input sg;
   input signed [`FAU_EW-1:0] ex;
   input [`FAU_MW-1:0] m;
   input trn;
   input b32;
   integer rpos;
   reg [`FAU_MW:0] t;
   reg rb;
   reg st;
   reg inc;
   reg signed [`FAU_EW-1:0] e2;
   reg [`FAU_FRAC_HI:0] nmax;
   begin
      rpos = b32 ? `FAU_RPOS32 : `FAU_RPOS40;
      rb = m[rpos];
      st = |(m & ((`FAU_MW'h1 << rpos) - `FAU_MW'h1));
      t = {1'b0, m} >> (rpos + 1);
      // (RL2) Nearest-even or truncate
      inc = ~trn & rb & (st | t[0]);
      t = t + {{`FAU_MW{1'b0}}, inc};
      t = t << (rpos + 1);
      e2 = ex;
      if (t[`FAU_MW]) begin
         t = t >> 1;
         e2 = ex + 1;
      end
      nmax = {(`FAU_FRAC_HI+1){1'b1}} << (rpos - `FAU_RPOS40);
      if (m == {`FAU_MW{1'b0}}) begin
         fau_finish = {3'b001, sg, {(`FAU_W-1){1'b0}}};
      // (RL3) Saturate on overflow
      end else if (e2 >= `FAU_E_OVF) begin
         if (trn)
            fau_finish = {3'b100, sg, `FAU_EXP_NMAX, nmax};
         else
            fau_finish = {3'b100, sg, `FAU_EXP_MAX, {(`FAU_FRAC_HI+1){1'b0}}};
      // (RL3) Denormal becomes signed zero
      end else if (e2 <= `FAU_E_DEN) begin
         fau_finish = {3'b011, sg, {(`FAU_W-1){1'b0}}};
      end else begin
         fau_finish = {3'b000, sg, e2[7:0], t[`FAU_M_TOP-1:`FAU_FRAC_LSB]};
      end
   end
endfunction

// Order key over sign-magnitude with flushed zeros equal
function [`FAU_W-1:0] fau_key;
   input sg;
   input [`FAU_MAG_HI:0] mag;
   begin
      if (mag == {(`FAU_MAG_HI+1){1'b0}})
         fau_key = {1'b1, mag};
      else if (sg)
         fau_key = {1'b0, ~mag};
      else
         fau_key = {1'b1, mag};
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Operand classification

wire sx = float_src_x_i[`FAU_SIGN];
wire sy = float_src_y_i[`FAU_SIGN];
wire [7:0] ex_x = float_src_x_i[`FAU_EXP_HI:`FAU_EXP_LO];
wire [7:0] ex_y = float_src_y_i[`FAU_EXP_HI:`FAU_EXP_LO];
wire [`FAU_FRAC_HI:0] fr_x = float_src_x_i[`FAU_FRAC_HI:0];
wire [`FAU_FRAC_HI:0] fr_y = float_src_y_i[`FAU_FRAC_HI:0];
wire zx = (ex_x == `FAU_EXP_ZERO);
wire zy = (ex_y == `FAU_EXP_ZERO);
wire spx = (ex_x == `FAU_EXP_MAX);
wire spy = (ex_y == `FAU_EXP_MAX);
wire nanx = spx & (|fr_x);
wire nany = spy & (|fr_y);
wire infx = spx & ~(|fr_x);
wire infy = spy & ~(|fr_y);
// (RL5) Denormal flush
wire [`FAU_MAG_HI:0] mag_x = zx ? {(`FAU_MAG_HI+1){1'b0}} : float_src_x_i[`FAU_MAG_HI:0];
wire [`FAU_MAG_HI:0] mag_y = zy ? {(`FAU_MAG_HI+1){1'b0}} : float_src_y_i[`FAU_MAG_HI:0];
wire [31:0] fraction_extract_op_x = zx ? 32'h00000000 : {1'b1, fr_x};
wire [31:0] fraction_extract_op_y = zy ? 32'h00000000 : {1'b1, fr_y};
wire mzero_x = (mag_x == {(`FAU_MAG_HI+1){1'b0}});

////////////////////////////////////////////////////////////////////////////////
// Average datapath: align, add or subtract, normalise, halve

wire swap = (mag_y > mag_x);
wire sb = swap ? sy : sx;
wire [7:0] eb = swap ? ex_y : ex_x;
wire [7:0] es = swap ? ex_x : ex_y;
wire [31:0] mb = swap ? fraction_extract_op_y : fraction_extract_op_x;
wire [31:0] ms = swap ? fraction_extract_op_x : fraction_extract_op_y;
wire [7:0] ediff = eb - es;
wire [`FAU_MW-1:0] al_b = {1'b0, mb, `FAU_GUARD};
wire [`FAU_MW-1:0] al_s = {1'b0, ms, `FAU_GUARD} >> ediff;
wire [`FAU_MW-1:0] sum = (sx ^ sy) ? (al_b - al_s) : (al_b + al_s);

reg [5:0] lz;
reg [31:0] lz_pos;
integer i;
always @* begin
   lz = 6'h00;
   lz_pos = 32'h00000000;
   for (i = 0; i < `FAU_MW; i = i + 1) begin
      if (sum[i]) begin
         lz_pos = `FAU_M_TOP - i;
         lz = lz_pos[5:0];
      end
   end
end

wire [`FAU_MW-1:0] avg_norm = sum << lz;
wire avg_sign = (sum == {`FAU_MW{1'b0}}) ? (sx & sy) : sb;
// (RL1) Halving: carry slot already sits one above, so no extra bump
wire signed [`FAU_EW-1:0] avg_exp = $signed({{(`FAU_EW-8){1'b0}}, eb})
                                  - $signed({{(`FAU_EW-6){1'b0}}, lz});
wire [`FAU_W+2:0] avg_fin = fau_finish(avg_sign, avg_exp, avg_norm, rnd_trunc_i, rnd_b32_i);

////////////////////////////////////////////////////////////////////////////////
// Round and scale datapaths

wire signed [`FAU_EW-1:0] x_exp_w = $signed({{(`FAU_EW-8){1'b0}}, ex_x});
// (RL12) Always the 32-bit boundary
// Hidden bit goes to the top slot, where the shared rounder expects it
wire [`FAU_W+2:0] rnd_fin = fau_finish(sx, x_exp_w, {fraction_extract_op_x, `FAU_GUARD, 1'b0},
                                       rnd_trunc_i, 1'b1);
// (RL13) Integer added to exponent
wire signed [`FAU_EW-1:0] scl_exp = x_exp_w
                                  + $signed({{(`FAU_EW-32){fixed_scale_src_i[31]}},
                                             fixed_scale_src_i});
// Mantissa is exact, so the 40-bit boundary never rounds
wire [`FAU_W+2:0] scl_fin = fau_finish(sx, scl_exp, {fraction_extract_op_x, `FAU_GUARD, 1'b0},
                                       rnd_trunc_i, 1'b0);

////////////////////////////////////////////////////////////////////////////////
// Compare

wire [`FAU_W-1:0] key_x = fau_key(sx, mag_x);
wire [`FAU_W-1:0] key_y = fau_key(sy, mag_y);
wire cmp_eq = (key_x == key_y);
wire cmp_lt = (key_x < key_y);

////////////////////////////////////////////////////////////////////////////////
// Result and flag selection

reg [`FAU_W-1:0] res_d;
reg zf_d;
reg uf_d;
reg nf_d;
reg vf_d;
reg sf_d;
reg if_d;
reg we_d;
wire any_nan = nanx | nany;
wire [`FAU_W-1:0] ones = {`FAU_W{1'b1}};

always @* begin
   res_d = result_o;
   zf_d = 1'b0;
   uf_d = 1'b0;
   nf_d = 1'b0;
   vf_d = 1'b0;
   sf_d = 1'b0;
   if_d = nanx;
   we_d = 1'b1;
   case (op_code_i)
      `FAU_OP_AVERAGE: begin
         // (RL4) Average flag set
         if_d = any_nan | (infx & infy & (sx ^ sy));
         if (if_d) begin
            res_d = ones;
         end else if (infx | infy) begin
            res_d = infx ? float_src_x_i : float_src_y_i;
            nf_d = res_d[`FAU_SIGN];
         end else begin
            res_d = avg_fin[`FAU_W-1:0];
            vf_d = avg_fin[`FAU_W+2];
            uf_d = avg_fin[`FAU_W+1];
            zf_d = avg_fin[`FAU_W];
            nf_d = avg_fin[`FAU_SIGN];
         end
      end
      `FAU_OP_COMPARE: begin
         // (RL6) Compare flags
         we_d = 1'b0;
         if_d = any_nan;
         zf_d = ~any_nan & cmp_eq;
         nf_d = ~any_nan & cmp_lt;
      end
      `FAU_OP_NEGATE: begin
         // (RL9) Sign inverted
         res_d = nanx ? ones : {~sx, mag_x};
         zf_d = ~nanx & mzero_x;
         nf_d = ~nanx & ~sx;
      end
      `FAU_OP_MAGNITUDE: begin
         // (RL10) Sign forced clear
         res_d = nanx ? ones : {1'b0, mag_x};
         zf_d = ~nanx & mzero_x;
         sf_d = sx;
      end
      `FAU_OP_PASS: begin
         // (RL11) Copy through
         res_d = nanx ? ones : {sx, mag_x};
         zf_d = ~nanx & mzero_x;
         nf_d = ~nanx & sx;
      end
      `FAU_OP_ROUND: begin
         // (RL12) Round flags
         if (nanx) begin
            res_d = ones;
         end else if (infx) begin
            res_d = float_src_x_i;
            nf_d = sx;
         end else begin
            res_d = rnd_fin[`FAU_W-1:0];
            vf_d = rnd_fin[`FAU_W+2];
            zf_d = rnd_fin[`FAU_W];
            nf_d = sx;
         end
      end
      `FAU_OP_EXP_SCALE: begin
         // (RL14) Scale flags
         if (nanx) begin
            res_d = ones;
         end else if (infx) begin
            res_d = float_src_x_i;
            nf_d = sx;
         end else begin
            res_d = scl_fin[`FAU_W-1:0];
            vf_d = scl_fin[`FAU_W+2];
            uf_d = scl_fin[`FAU_W+1];
            zf_d = scl_fin[`FAU_W];
            nf_d = sx;
         end
      end
      `FAU_OP_FRAC_EXTRACT: begin
         // (RL16) Special inputs
         if_d = spx;
         sf_d = sx;
         // (RL15) Left-justified 1.31
         res_d = spx ? ones : {fraction_extract_op_x, `FAU_FIX_PAD};
         zf_d = ~spx & (fraction_extract_op_x == 32'h00000000);
      end
      default: begin
         we_d = 1'b0;
         if_d = 1'b0;
      end
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// Registers; operands from the sequencer share this clock, no synchroniser

always @(posedge ref_clk_i or negedge arst_n_i) begin
   if (!arst_n_i) begin
      result_o <= {`FAU_W{1'b0}};
      result_we_o <= 1'b0;
      zero_flag_o <= 1'b0;
      underflow_flag_o <= 1'b0;
      negative_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
      carry_flag_o <= 1'b0;
      sign_flag_o <= 1'b0;
      invalid_flag_o <= 1'b0;
      cmp_history_o <= {`FAU_CMP_W{1'b0}};
   end else begin
      result_we_o <= op_valid_i & we_d;
      if (op_valid_i) begin
         if (we_d)
            result_o <= res_d;
         // (RL17) Flags with result
         zero_flag_o <= zf_d;
         underflow_flag_o <= uf_d;
         negative_flag_o <= nf_d;
         overflow_flag_o <= vf_d;
         carry_flag_o <= 1'b0;
         sign_flag_o <= sf_d;
         invalid_flag_o <= if_d;
         if (op_code_i == `FAU_OP_COMPARE) begin
            // (RL7) Shift history right
            // (RL8) Greater-than enters at top
            cmp_history_o <= {~zf_d & ~nf_d, cmp_history_o[`FAU_CMP_W-1:1]};
         end
      end
   end
end

endmodule

// >>> fau_core_monitor.sv
`include "fau_defs.vh"
module fau_core_monitor (
   input wire ref_clk_i,
   input wire arst_n_i,
   input wire op_valid_i,
   input wire [`FAU_OP_W-1:0] op_code_i,
   input wire [`FAU_W-1:0] float_src_x_i,
   input wire [`FAU_W-1:0] float_src_y_i,
   input wire [31:0] fixed_scale_src_i,
   input wire rnd_trunc_i,
   input wire rnd_b32_i,
   input wire [`FAU_W-1:0] result_o,
   input wire result_we_o,
   input wire zero_flag_o,
   input wire underflow_flag_o,
   input wire negative_flag_o,
   input wire overflow_flag_o,
   input wire carry_flag_o,
   input wire sign_flag_o,
   input wire invalid_flag_o,
   input wire [`FAU_CMP_W-1:0] cmp_history_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   wire is_cmp = op_code_i == `FAU_OP_COMPARE;
   wire x_inf = &float_src_x_i[`FAU_EXP_HI:`FAU_EXP_LO];
   wire x_nan = x_inf && (|float_src_x_i[`FAU_FRAC_HI:0]);
   wire [6:0] flags = {zero_flag_o, underflow_flag_o, negative_flag_o, overflow_flag_o,
      carry_flag_o, sign_flag_o, invalid_flag_o};
   ////////////////////////////////////////////////////////////////////////////////
   we_pulse_a: assert property (op_valid_i && !is_cmp |=> result_we_o)
      else $error("result strobe missing");
   idle_quiet_a: assert property (!op_valid_i |=> !result_we_o && $stable(flags))
      else $error("outputs moved while idle");
   hist_shift_a: assert property (op_valid_i && is_cmp |=> !result_we_o &&
      cmp_history_o == {!zero_flag_o && !negative_flag_o, $past(cmp_history_o[7:1])})
      else $error("compare history wrong");
   hist_hold_a: assert property (op_valid_i && !is_cmp |=> $stable(cmp_history_o))
      else $error("history moved without compare");
   cmp_clear_a: assert property (op_valid_i && is_cmp |=> {flags[5], flags[3:1]} == 4'h0)
      else $error("compare left stray flags");
   nan_ones_a: assert property (op_valid_i && !is_cmp && x_nan |=> &result_o && invalid_flag_o)
      else $error("nan input not all ones");
   neg_flags_a: assert property (op_valid_i && op_code_i == `FAU_OP_NEGATE |=>
      invalid_flag_o || (negative_flag_o == result_o[39] && zero_flag_o == (result_o[38:0] == 0)))
      else $error("negate flags wrong");
   mag_sign_a: assert property (op_valid_i && op_code_i == `FAU_OP_MAGNITUDE |=>
      sign_flag_o == $past(float_src_x_i[`FAU_SIGN]) && (invalid_flag_o || !result_o[39]))
      else $error("magnitude sign wrong");
   frac_low_a: assert property (op_valid_i && op_code_i == `FAU_OP_FRAC_EXTRACT && !x_inf |=>
      result_o[7:0] == 8'h00 && !negative_flag_o && !overflow_flag_o)
      else $error("fraction field wrong");
   carry_zero_a: assert property (op_valid_i |=> !carry_flag_o)
      else $error("carry flag set");
endmodule
bind fau_core fau_core_monitor fau_core_monitor_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
   .op_valid_i(op_valid_i), .op_code_i(op_code_i), .float_src_x_i(float_src_x_i),
   .float_src_y_i(float_src_y_i), .fixed_scale_src_i(fixed_scale_src_i),
   .rnd_trunc_i(rnd_trunc_i), .rnd_b32_i(rnd_b32_i), .result_o(result_o),
   .result_we_o(result_we_o), .zero_flag_o(zero_flag_o), .underflow_flag_o(underflow_flag_o),
   .negative_flag_o(negative_flag_o), .overflow_flag_o(overflow_flag_o),
   .carry_flag_o(carry_flag_o), .sign_flag_o(sign_flag_o), .invalid_flag_o(invalid_flag_o),
   .cmp_history_o(cmp_history_o));

// >>> fau_defs.vh
`ifndef FAU_DEFS_VH
`define FAU_DEFS_VH

// Operation codes on op_code_i
`define FAU_OP_W 3
`define FAU_OP_AVERAGE 3'h0
`define FAU_OP_COMPARE 3'h1
`define FAU_OP_NEGATE 3'h2
`define FAU_OP_MAGNITUDE 3'h3
`define FAU_OP_PASS 3'h4
`define FAU_OP_ROUND 3'h5
`define FAU_OP_EXP_SCALE 3'h6
`define FAU_OP_FRAC_EXTRACT 3'h7

// Extended float layout: sign, 8-bit biased exponent, 31-bit fraction
`define FAU_W 40
`define FAU_SIGN 39
`define FAU_EXP_HI 38
`define FAU_EXP_LO 31
`define FAU_FRAC_HI 30
`define FAU_MAG_HI 38
`define FAU_EXP_MAX 8'hFF
`define FAU_EXP_NMAX 8'hFE
`define FAU_EXP_ZERO 8'h00

// Working mantissa: carry at 40, hidden bit at 39, eight guard bits below
`define FAU_MW 41
`define FAU_M_TOP 40
`define FAU_GUARD 8'h00
`define FAU_ROUND_PAD 9'h000
`define FAU_RPOS32 16
`define FAU_RPOS40 8
`define FAU_FRAC_LSB 9

// Wide signed exponent arithmetic
`define FAU_EW 34
`define FAU_E_OVF 34'sh0FF
`define FAU_E_DEN 34'sh000

// Fixed-point destination: 32-bit field above an 8-bit extension
`define FAU_FIX_PAD 8'h00
`define FAU_CMP_W 8

`endif

// >>> fau_regfile.sv
module fau_regfile (
   input wire ref_clk_i,
   input wire arst_n_i,
   input wire [39:0] result_i,
   input wire result_we_i,
   output logic [39:0] dest_o,
   output logic [15:0] writes_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Destination register takes every strobed result
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dest_o <= 40'h0000000000;
         writes_o <= 16'h0000;
      end else if (result_we_i) begin
         dest_o <= result_i;
         writes_o <= writes_o + 16'h0001;
      end
   end
endmodule

// >>> tb.sv
`include "fau_defs.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [39:0] r; logic [7:0] f; logic [7:0] h;} fau_note_t;
   logic ref_clk_i = 0, arst_n_i = 0, op_valid_i = 0, rnd_trunc_i = 0, rnd_b32_i = 0;
   logic [2:0] op_code_i = 0;
   logic [39:0] float_src_x_i = 0, float_src_y_i = 0, result_o, dest;
   logic [31:0] fixed_scale_src_i = 0;
   logic result_we_o, zf, uf, nf, vf, cf, sf, inv;
   logic [7:0] cmp_history_o, hist = 0;
   logic [15:0] writes, want_writes = 0;
   logic [39:0] x;
   logic [39:0] last_r = 0;
   int errors = 0, checked = 0;
   fau_note_t notes[$];
   fau_core fau_core_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
      .op_code_i(op_code_i), .float_src_x_i(float_src_x_i), .float_src_y_i(float_src_y_i),
      .fixed_scale_src_i(fixed_scale_src_i), .rnd_trunc_i(rnd_trunc_i), .rnd_b32_i(rnd_b32_i),
      .result_o(result_o), .result_we_o(result_we_o), .zero_flag_o(zf), .underflow_flag_o(uf),
      .negative_flag_o(nf), .overflow_flag_o(vf), .carry_flag_o(cf), .sign_flag_o(sf),
      .invalid_flag_o(inv), .cmp_history_o(cmp_history_o));
   fau_regfile fau_regfile_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .result_i(result_o),
      .result_we_i(result_we_o), .dest_o(dest), .writes_o(writes));
   always #4 ref_clk_i = ~ref_clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally(input bit bad, input logic [63:0] g, e);
      checked++;
      if (bad) begin
         errors++;
         $display("unexpected at %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_res(input logic [39:0] g, e);
      tally(g !== e, g, e);
   endtask
   task automatic cmp_flags(input logic [7:0] g, e);
      tally(g !== e, g, e);
   endtask
   task automatic cmp_count(input logic [15:0] g, e);
      tally(g !== e, g, e);
   endtask
   task automatic wrap_up;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One request per call; consecutive calls land on consecutive edges
   task automatic do_op(input logic [2:0] op, input logic [39:0] a, b, input logic [31:0] k,
         input logic [1:0] m, input logic [39:0] r, input logic [6:0] f);
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1;
      op_code_i = op;
      float_src_x_i = a;
      float_src_y_i = b;
      fixed_scale_src_i = k;
      {rnd_trunc_i, rnd_b32_i} = m;
      if (op != `FAU_OP_COMPARE) begin
         want_writes++;
         last_r = r;
      end
      notes.push_back('{r, {op != `FAU_OP_COMPARE, f}, hist});
   endtask
   function automatic logic signed [40:0] key(input logic [39:0] a);
      logic [40:0] mag;
      mag = a[38:31] == 8'h00 ? 41'h0 : {2'b00, a[38:0]};
      return a[39] ? -$signed(mag) : $signed(mag);
   endfunction
   task automatic do_cmp(input logic [39:0] a, b);
      logic z, n;
      z = key(a) == key(b);
      n = key(a) < key(b);
      hist = {!z && !n, hist[7:1]};
      do_op(`FAU_OP_COMPARE, a, b, 0, 0, 40'h0, {z, 1'b0, n, 4'h0});
   endtask
   // Reference for negate, magnitude, pass and fraction extract; denormals flush to signed zero
   function automatic logic [46:0] ref_op(input logic [2:0] op, input logic [39:0] a);
      logic [39:0] r;
      logic z;
      r = a[38:31] == 8'h00 ? {a[39], 39'h0} : a;
      z = r[38:0] == 0;
      case (op)
         `FAU_OP_NEGATE: return {r ^ 40'h8000000000, z, 1'b0, ~r[39], 4'h0};
         `FAU_OP_MAGNITUDE: return {1'b0, r[38:0], z, 4'h0, a[39], 1'b0};
         `FAU_OP_PASS: return {r, z, 1'b0, r[39], 4'h0};
         default: return {z ? 40'h0 : {1'b1, r[30:0], 8'h00}, z, 4'h0, a[39], 1'b0};
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk_i) begin
      fau_note_t nt;
      if (arst_n_i && op_valid_i) begin
         #2;
         nt = notes.pop_front();
         if (nt.f[7])
            cmp_res(result_o, nt.r);
         cmp_flags({result_we_o, zf, uf, nf, vf, cf, sf, inv}, nt.f);
         cmp_flags(cmp_history_o, nt.h);
      end
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      wrap_up;
   end
   initial begin
      void'($urandom(70124));
      repeat (5) @(posedge ref_clk_i);
      #1;
      arst_n_i = 1;
      do_op(0, 40'h3F80000000, 40'h4040000000, 0, 0, 40'h4000000000, 7'h00);
      for (int m = 0; m < 4; m++)
         do_op(0, 40'h3F80000000, 40'h3F80000003, 0, m, m[0] ? 40'h3F80000000 :
            (m[1] ? 40'h3F80000001 : 40'h3F80000002), 7'h00);
      do_op(0, 40'h0080000000, 40'h0, 0, 0, 40'h0, 7'h60);
      do_op(0, 40'hBF80000000, 40'hC040000000, 0, 0, 40'hC000000000, 7'h10);
      do_op(0, 40'h3F80000000, 40'hBF80000000, 0, 0, 40'h0, 7'h40);
      do_op(3, 40'h7FC0000000, 0, 0, 0, {40{1'b1}}, 7'h01);
      do_op(7, 40'hFF80000000, 0, 0, 0, {40{1'b1}}, 7'h03);
      do_op(7, 40'h3F80000000, 0, 0, 0, 40'h8000000000, 7'h00);
      do_op(5, 40'h3F80000080, 0, 0, 0, 40'h3F80000000, 7'h00);
      do_op(5, 40'h3F80000180, 0, 0, 0, 40'h3F80000200, 7'h00);
      do_op(5, 40'h3F80000180, 0, 0, 2, 40'h3F80000100, 7'h00);
      do_op(5, 40'h7F7FFFFFFF, 0, 0, 0, 40'h7F80000000, 7'h08);
      do_op(5, 40'h7F7FFFFFFF, 0, 0, 2, 40'h7F7FFFFF00, 7'h00);
      do_op(6, 40'h3F80000000, 0, 1, 0, 40'h4000000000, 7'h00);
      do_op(6, 40'h3F80000000, 0, 200, 0, 40'h7F80000000, 7'h08);
      do_op(6, 40'h3F80000000, 0, 200, 2, 40'h7F7FFFFFFF, 7'h08);
      do_op(6, 40'h3F80000000, 0, -127, 0, 40'h0, 7'h60);
      do_op(6, 40'hBF80000000, 0, -1, 0, 40'hBF00000000, 7'h10);
      hist = {1'b1, hist[7:1]};
      do_op(1, 40'h7FC0000000, 40'h3F80000000, 0, 0, 40'h0, 7'h01);
      do_cmp(40'h8000000000, 40'h0);
      do_cmp(40'h3F80000000, 40'h4040000000);
      $display("test directed done");
      for (int i = 0; i < 200; i++) begin
         logic [2:0] op;
         op = i % 5 == 0 ? 3'h1 : ($urandom_range(0, 3) == 0 ? 3'h7 : 3'(2 + $urandom_range(0, 2)));
         x = {$urandom_range(0, 1), 8'($urandom_range(op == 7 ? 1 : 0, 254)), 31'($urandom)};
         if (op == 1)
            do_cmp(x, i % 3 == 0 ? x : {1'($urandom), 8'($urandom_range(1, 254)), 31'($urandom)});
         else
            do_op(op, x, 0, 0, 0, ref_op(op, x) >> 7, ref_op(op, x));
      end
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 0;
      repeat (3) @(posedge ref_clk_i);
      cmp_count(writes, want_writes);
      cmp_res(dest, last_r);
      $display("test random done");
      wrap_up;
   end
endmodule
